//--- irq_queue_cfg.svh
`ifndef IRQ_QUEUE_CFG_SVH
`define IRQ_QUEUE_CFG_SVH

// Offset of the interrupt control port on the host bus.
`define CTRL_PORT_OFFSET   4'h1

// Values the host writes to the control port.
`define CMD_PREP_A         8'h02
`define CMD_PREP_B         8'h04
`define CMD_READ_CAUSE     8'h06

// Condition mask field positions.
`define COND_AXIS_LSB      0
`define COND_ALL_AXES      8
`define COND_POS_ERR       9
`define COND_LIMIT         10
`define COND_WATCHDOG      11
`define COND_RESERVED      12
`define COND_PROG_STOP     13
`define COND_CMD_DONE      14
`define COND_INPUT_EN      15

// Cause codes.
`define CODE_NONE          8'h00
`define CODE_AXIS_BASE     8'hD0
`define CODE_ALL_AXES      8'hD8
`define CODE_WATCHDOG      8'hD9
`define CODE_CMD_DONE      8'hDA
`define CODE_PROG_DONE     8'hDB
`define CODE_LIMIT         8'hC0
`define CODE_POS_ERR       8'hC8
`define CODE_INPUT_BASE    8'hE0
`define CODE_USER_BASE     8'hF0

// Reset values.
`define RST_COND_MASK      16'h0000
`define RST_INPUT_MASK     8'h00

`endif

//--- irq_queue_pkg.sv
package irq_queue_pkg;
  typedef logic [7:0]  cause_code_t;
  typedef logic [15:0] cond_mask_t;
  typedef logic [7:0]  input_mask_t;
  typedef enum logic [1:0] {
    PORT_IDLE,
    PORT_ARMED_A,
    PORT_READY
  } port_state_t;
endpackage

//--- cause_fifo.sv
`timescale 1ns/1ps
// In-order cause store; a push into a full store with no pop in the same cycle is dropped and flagged.
module cause_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head_data,
  output logic                  empty,
  output logic                  full,
  output logic                  overflow
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    wr_q;
  logic [AW:0]      cnt_q;
  logic             do_push;
  logic             do_pop;

  assign empty     = (cnt_q == '0);
  assign full      = (cnt_q == (AW+1)'(DEPTH));
  assign do_pop    = pop && !empty;
  assign do_push   = push && (!full || do_pop);
  assign overflow  = push && full && !do_pop;
  assign head_data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || flush) begin
      rd_q  <= '0;
      wr_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule // cause_fifo

//--- host_interrupt_queue.sv
// Summary of operation
// - One interrupt request line goes to the host, asserted for enabled causes and for user interrupts, shared by all of them.
// - Pending causes wait in an eight-entry queue in order of occurrence; a cause pushed into a full queue with no same-cycle service read is lost and flagged.
// - Issuing the interrupt-enable command empties the whole pending queue.
// - Condition mask bits 0-7 are axis motion complete, 8 all axes, 9 position error, 10 limit, 11 watchdog, 12 reserved, 13 program stopped, 14 command done.
// - Condition mask bit 15 enables input interrupts, with a second mask selecting inputs one to eight.
// - The position error condition clears its own enable after firing once.
// - When one input interrupt fires, all selected inputs, that one included, are disabled until the enable command is reissued.
// - Sixteen user interrupts from a command are queued whatever the condition masks hold.
// - Cause codes are 00 none, D0-D7 axes, D8 all axes, C8 position error, C0 limit, D9 watchdog, DA command done, DB program done.
// - Input interrupts report E1 to E8 and user interrupts report F0 to FF.
// - An enabled condition drives the host request line high once the host has prepared the line.
`timescale 1ns/1ps
`include "irq_queue_cfg.svh"

module host_interrupt_queue
  import irq_queue_pkg::*;
#(
  parameter int QUEUE_DEPTH = 8,
  parameter int NUM_INPUTS  = 8
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Command side, same clock domain.
  input  wire logic                  irq_enable_command,
  input  wire logic [15:0]           irq_enable_cond_mask,
  input  wire logic [NUM_INPUTS-1:0] irq_enable_input_mask,
  input  wire logic                  user_irq_command,
  input  wire logic [3:0]            user_irq_number,
  // Condition event pulses from the motion core, same clock domain.
  input  wire logic [15:0]           cond_event,
  // Digital input pins, asynchronous.
  input  wire logic [NUM_INPUTS-1:0] digital_in,
  // Host bus.
  input  wire logic [3:0]            host_addr,
  input  wire logic                  host_wr,
  input  wire logic                  host_rd,
  input  wire logic [7:0]            host_wdata,
  output logic      [7:0]            host_rdata,
  output logic                       host_irq,
  output logic                       line_prepared,
  output logic                       queue_overflow
);
  cond_mask_t                cond_mask_q;
  logic [NUM_INPUTS-1:0]     input_mask_q;
  logic [NUM_INPUTS-1:0]     din_meta_q;
  logic [NUM_INPUTS-1:0]     din_sync_q;
  logic [NUM_INPUTS-1:0]     din_prev_q;
  logic [NUM_INPUTS-1:0]     din_rise;
  port_state_t               port_state_q;
  logic                      prepared_q;
  logic                      read_armed_q;
  logic [7:0]                host_rdata_q;
  logic                      overflow_q;
  logic                      port_sel;
  logic                      svc_read;
  logic                      push;
  cause_code_t               push_code;
  logic                      pos_err_fire;
  logic                      input_fire;
  logic                      q_empty;
  cause_code_t               q_head;
  logic                      q_overflow;

  // Two flops before any logic sees the pins; the edge detector reads only the second.
  // The edge flop idles low like the pins, so leaving reset cannot fake a rising edge.
  always_ff @(posedge clk) begin
    if (srst) begin
      din_meta_q <= '0;
      din_sync_q <= '0;
      din_prev_q <= '0;
    end else begin
      din_meta_q <= digital_in;
      din_sync_q <= din_meta_q;
      din_prev_q <= din_sync_q;
    end
  end
  assign din_rise = din_sync_q & ~din_prev_q;

  // Precedence is user, position error, limit, watchdog, command done, program done, all axes, axes, inputs.
  // Pick one cause per cycle; simultaneous lower-priority causes are dropped, a trade for a single-port queue.
  always_comb begin
    push      = 1'b0;
    push_code = `CODE_NONE;
    pos_err_fire = 1'b0;
    input_fire   = 1'b0;
    if (user_irq_command) begin
      push      = 1'b1;
      push_code = `CODE_USER_BASE | {4'h0, user_irq_number};
    end else if (cond_event[`COND_POS_ERR] && cond_mask_q[`COND_POS_ERR]) begin
      push         = 1'b1;
      push_code    = `CODE_POS_ERR;
      pos_err_fire = 1'b1;
    end else if (cond_event[`COND_LIMIT] && cond_mask_q[`COND_LIMIT]) begin
      push      = 1'b1;
      push_code = `CODE_LIMIT;
    end else if (cond_event[`COND_WATCHDOG] && cond_mask_q[`COND_WATCHDOG]) begin
      push      = 1'b1;
      push_code = `CODE_WATCHDOG;
    end else if (cond_event[`COND_CMD_DONE] && cond_mask_q[`COND_CMD_DONE]) begin
      push      = 1'b1;
      push_code = `CODE_CMD_DONE;
    end else if (cond_event[`COND_PROG_STOP] && cond_mask_q[`COND_PROG_STOP]) begin
      push      = 1'b1;
      push_code = `CODE_PROG_DONE;
    end else if (cond_event[`COND_ALL_AXES] && cond_mask_q[`COND_ALL_AXES]) begin
      push      = 1'b1;
      push_code = `CODE_ALL_AXES;
    end else if (|(cond_event[7:0] & cond_mask_q[7:0])) begin
      push = 1'b1;
      for (int i = 7; i >= 0; i--) begin
        if (cond_event[i] && cond_mask_q[i]) begin
          push_code = `CODE_AXIS_BASE | 8'(i);
        end
      end
    end else if (cond_mask_q[`COND_INPUT_EN] && |(din_rise & input_mask_q)) begin
      push       = 1'b1;
      input_fire = 1'b1;
      for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
        if (din_rise[i] && input_mask_q[i]) begin
          push_code = `CODE_INPUT_BASE + 8'(i + 1);
        end
      end
    end
  end

  // Bit 12 is reserved; dropping it here keeps a stray set bit from ever arming a cause.
  localparam cond_mask_t COND_KEEP = ~(cond_mask_t'(1) << `COND_RESERVED);

  // A new enable command wins over the self-clearing of enables in the same cycle.
  // Any input that fires zeroes the whole input mask, so only a new enable command re-arms the inputs.
  always_ff @(posedge clk) begin
    if (srst) begin
      cond_mask_q  <= `RST_COND_MASK;
      input_mask_q <= `RST_INPUT_MASK;
    end else if (irq_enable_command) begin
      cond_mask_q  <= irq_enable_cond_mask & COND_KEEP;
      input_mask_q <= irq_enable_input_mask;
    end else begin
      if (pos_err_fire) begin
        cond_mask_q[`COND_POS_ERR] <= 1'b0;
      end
      if (input_fire) begin
        input_mask_q <= '0;
      end
    end
  end

  // Only the control port offset is decoded; reads and writes elsewhere are ignored.
  assign port_sel = (host_addr == `CTRL_PORT_OFFSET);
  // One write of 6 arms exactly one service read, so a repeated read cannot pop a second cause.
  assign svc_read = port_sel && host_rd && read_armed_q;

  // Tracks the 2-then-4 preparation sequence written by the host.
  always_ff @(posedge clk) begin
    if (srst) begin
      port_state_q <= PORT_IDLE;
    end else if (port_sel && host_wr) begin
      case (port_state_q)
        PORT_IDLE:    port_state_q <= (host_wdata == `CMD_PREP_A) ? PORT_ARMED_A : PORT_IDLE;
        PORT_ARMED_A: port_state_q <= (host_wdata == `CMD_PREP_B) ? PORT_READY :
                                      (host_wdata == `CMD_PREP_A) ? PORT_ARMED_A : PORT_IDLE;
        PORT_READY:   port_state_q <= (host_wdata == `CMD_PREP_A) ? PORT_ARMED_A : PORT_READY;
        default:      port_state_q <= PORT_IDLE;
      endcase
    end
  end
  // A fresh write of 2 restarts preparation, letting the host run the sequence again at any time.
  assign prepared_q = (port_state_q == PORT_READY);

  always_ff @(posedge clk) begin
    if (srst) begin
      read_armed_q <= 1'b0;
    end else if (port_sel && host_wr) begin
      read_armed_q <= (host_wdata == `CMD_READ_CAUSE);
    end else if (svc_read) begin
      read_armed_q <= 1'b0;
    end
  end

  // An unarmed read returns none and leaves the queue untouched.
  always_ff @(posedge clk) begin
    if (srst) begin
      host_rdata_q <= `CODE_NONE;
    end else if (svc_read) begin
      host_rdata_q <= q_empty ? `CODE_NONE : q_head;
    end else if (port_sel && host_rd) begin
      host_rdata_q <= `CODE_NONE;
    end
  end

  // Sticky until the next enable command; that command also flushes, so the clear wins over a same-cycle push.
  always_ff @(posedge clk) begin
    if (srst || irq_enable_command) begin
      overflow_q <= 1'b0;
    end else if (q_overflow) begin
      overflow_q <= 1'b1;
    end
  end

  // A push into a full queue with no same-cycle service read is lost; the sticky overflow flag tells the host that a cause went missing.
  cause_fifo #(
    .WIDTH (8),
    .DEPTH (QUEUE_DEPTH)
  ) u_queue (
    .clk       (clk),
    .srst      (srst),
    .flush     (irq_enable_command),
    .push      (push),
    .push_data (push_code),
    .pop       (svc_read),
    .head_data (q_head),
    .empty     (q_empty),
    .full      (),
    .overflow  (q_overflow)
  );

  assign host_rdata     = host_rdata_q;
  // The line stays low until the host has prepared it, even with causes waiting.
  assign host_irq       = prepared_q && !q_empty;
  assign line_prepared  = prepared_q;
  assign queue_overflow = overflow_q;
endmodule // host_interrupt_queue

//--- irq_checker.sv
`timescale 1ns/1ps
module irq_checker (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       irq_enable_command,
  input wire logic       user_irq_command,
  input wire logic [3:0] host_addr,
  input wire logic       host_wr,
  input wire logic       host_rd,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic       host_irq,
  input wire logic       line_prepared,
  input wire logic       queue_overflow
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire logic p1 = host_addr == 4'h1;
  property p_gate; host_irq |-> line_prepared; endproperty
  a_gate: assert property (p_gate) else $error("irq high on unprepared line");
  property p_flush; irq_enable_command |=> !host_irq; endproperty
  a_flush: assert property (p_flush) else $error("queue not emptied by enable");
  property p_ovf_clr; irq_enable_command |=> !queue_overflow; endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow kept over enable");
  property p_user; user_irq_command && line_prepared && !irq_enable_command && !host_wr |=> host_irq; endproperty
  a_user: assert property (p_user) else $error("user request not signalled");
  property p_dbl; host_rd && p1 ##1 host_rd && p1 |=> host_rdata == 8'h00; endproperty
  a_dbl: assert property (p_dbl) else $error("unarmed read returned a cause");
  property p_hold; !(host_rd && p1) |=> $stable(host_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_prep; host_wr && p1 && host_wdata == 8'h02 ##1 host_wr && p1 && host_wdata == 8'h04 |=> line_prepared;
  endproperty
  a_prep: assert property (p_prep) else $error("line not prepared by 2 then 4");
  property p_fall; $fell(host_irq) |-> $past(host_rd || host_wr || irq_enable_command); endproperty
  a_fall: assert property (p_fall) else $error("request line dropped with no cause");
  c_irq: cover property ($rose(host_irq));
  c_prep: cover property ($rose(line_prepared));
  c_full: cover property ($rose(queue_overflow));
endmodule // irq_checker

bind host_interrupt_queue irq_checker u_chk (.clk(clk), .srst(srst), .irq_enable_command(irq_enable_command),
  .user_irq_command(user_irq_command), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
  .host_wdata(host_wdata), .host_rdata(host_rdata), .host_irq(host_irq), .line_prepared(line_prepared),
  .queue_overflow(queue_overflow));

//--- host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk,
  output logic      [3:0] host_addr,
  output logic            host_wr,
  output logic            host_rd,
  output logic      [7:0] host_wdata
);
  initial begin
    host_addr = 4'h0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 8'h00;
  end
  // Released lines flip each idle cycle, so a stale address or data byte matches the live one again every second idle cycle.
  task automatic bus(input logic wr, input logic rd, input logic [7:0] d);
    @(posedge clk);
    host_wr <= wr;
    host_rd <= rd;
    host_addr <= (wr || rd) ? 4'h1 : ~host_addr;
    host_wdata <= wr ? d : ~host_wdata;
  endtask
  task automatic prepare();
    bus(1'b1, 1'b0, 8'h02);
    bus(1'b1, 1'b0, 8'h04);
    bus(1'b0, 1'b0, 8'h00);
  endtask
  // The gap models a slow host between arming and reading.
  task automatic service(input int gap);
    bus(1'b1, 1'b0, 8'h06);
    repeat (gap) bus(1'b0, 1'b0, 8'h00);
    bus(1'b0, 1'b1, 8'h00);
    bus(1'b0, 1'b0, 8'h00);
  endtask
endmodule // host_model

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top
  import irq_queue_pkg::*;
  ;
  logic clk, srst, irq_enable_command, user_irq_command, rd_d, host_wr, host_rd, host_irq, line_prepared, queue_overflow;
  cond_mask_t irq_enable_cond_mask, cond_event;
  input_mask_t irq_enable_input_mask, digital_in;
  logic [3:0] user_irq_number, host_addr;
  logic [7:0] host_wdata;
  cause_code_t host_rdata, exp_q[$], uq[8];
  logic [31:0] seed = 32'h0000_5ee9;
  int err_total, checked, cyc;
  int bits[14] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 13, 14};
  cause_code_t codes[14] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hd7, 8'hd8, 8'hc8, 8'hc0, 8'hd9,
                             8'hdb, 8'hda};
  host_interrupt_queue #(.QUEUE_DEPTH(8), .NUM_INPUTS(8)) dut (.clk(clk), .srst(srst),
    .irq_enable_command(irq_enable_command), .irq_enable_cond_mask(irq_enable_cond_mask),
    .irq_enable_input_mask(irq_enable_input_mask), .user_irq_command(user_irq_command),
    .user_irq_number(user_irq_number), .cond_event(cond_event), .digital_in(digital_in), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_irq(host_irq),
    .line_prepared(line_prepared), .queue_overflow(queue_overflow));
  host_model hm (.clk(clk), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic svc(input cause_code_t e, input int gap);
    exp_q.push_back(e);
    hm.service(gap);
  endtask
  task automatic enable_cmd(input cond_mask_t m, input input_mask_t n);
    @(posedge clk);
    irq_enable_command <= 1'b1;
    irq_enable_cond_mask <= m;
    irq_enable_input_mask <= n;
    @(posedge clk);
    irq_enable_command <= 1'b0;
  endtask
  task automatic cond(input int b);
    @(posedge clk);
    cond_event <= 16'h0001 << b;
    @(posedge clk);
    cond_event <= 16'h0000;
  endtask
  task automatic user(input logic [3:0] k);
    @(posedge clk);
    user_irq_command <= 1'b1;
    user_irq_number <= k;
    @(posedge clk);
    user_irq_command <= 1'b0;
  endtask
  // Each read result is compared against the oldest note the driver left.
  always @(posedge clk) begin
    if (rd_d) check(host_rdata, exp_q.pop_front());
    rd_d <= host_rd && host_addr == 4'h1;
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    srst = 1'b1;
    {irq_enable_command, user_irq_command} = 2'h0;
    {irq_enable_cond_mask, cond_event, irq_enable_input_mask, digital_in, user_irq_number} = 52'h0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    #1 check({host_irq, line_prepared, queue_overflow, 5'h00}, 8'h00);
    hm.prepare();
    #1 check({7'h00, line_prepared}, 8'h01);
    enable_cmd(16'h6fff, 8'h00);
    foreach (bits[i]) begin
      cond(bits[i]);
      #1 check({7'h00, host_irq}, 8'h01);
      svc(codes[i], i % 3);
    end
    cond(9);
    svc(8'h00, 0);
    enable_cmd(16'h0001, 8'h00);
    cond(1);
    svc(8'h00, 0);
    $display("condition codes done");
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      if (i < 8) uq[i] = {4'hf, seed[3:0]};
      user(seed[3:0]);
    end
    #1 check({7'h00, queue_overflow}, 8'h01);
    foreach (uq[i]) svc(uq[i], seed[i] ? 2 : 0);
    svc(8'h00, 0);
    #1 check({7'h00, host_irq}, 8'h00);
    $display("user queue done");
    user(4'h3);
    enable_cmd(16'h0000, 8'h00);
    #1 check({6'h00, host_irq, queue_overflow}, 8'h00);
    svc(8'h00, 1);
    enable_cmd(16'h8000, 8'h06);
    @(posedge clk) digital_in <= 8'h02;
    repeat (6) @(posedge clk);
    svc(8'he2, 0);
    @(posedge clk) digital_in <= 8'h06;
    repeat (6) @(posedge clk);
    svc(8'h00, 0);
    $display("inputs done");
    user(4'h5);
    exp_q.push_back(8'hf5);
    exp_q.push_back(8'h00);
    hm.bus(1'b1, 1'b0, 8'h06);
    hm.bus(1'b0, 1'b1, 8'h00);
    hm.bus(1'b0, 1'b1, 8'h00);
    hm.bus(1'b0, 1'b0, 8'h00);
    repeat (3) @(posedge clk);
    $display("double read done");
    final_report();
  end
endmodule // tb_top
